// ===== bench/tpsm_host.sv
// Bus master model driving the touch controller link
`default_nettype none
module tpsm_host (
   // Resolved data line
   input wire logic sda_i,
   // Open-drain pulls, high pulls the line low
   output logic scl_low_o,
   output logic sda_low_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Both lines released, clock stands high outside frames
   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end
   // One bit, data changes while clock is low, 64 ns per bit
   task automatic bit_io(input logic b, output logic r);
      sda_low_o = ~b;
      #16 scl_low_o = 1'b0;
      #16 r = sda_i;
      #16 scl_low_o = 1'b1;
      #16;
   endtask
   // Byte MSB first, ninth bit returns the acknowledge
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // Start, address with write, pointer, one data byte, stop
   task automatic xfer(input logic [6:0] a, input logic [7:0] p,
                       input logic [7:0] d, output logic ack);
      logic r;
      sda_low_o = 1'b1;
      #32 scl_low_o = 1'b1;
      #16;
      send({a, 1'b0}, ack);
      if (ack) begin
         send(p, r);
         send(d, r);
      end
      sda_low_o = 1'b1;
      #16 scl_low_o = 1'b0;
      #32 sda_low_o = 1'b0;
      #32;
   endtask
   // Command sent once acknowledged, retried on refusal
   task automatic xfer_retry(input logic [6:0] a, input logic [7:0] p,
                             input logic [7:0] d, output logic ack);
      ack = 1'b0;
      for (int i = 0; i < 8 && !ack; i++) begin
         xfer(a, p, d, ack);
      end
   endtask
endmodule
`default_nettype wire

// ===== bench/tpsm_tb_top.sv
// Self-checking bench for the touch power state manager
`default_nettype none
module tpsm_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {int kind; logic exp; logic aux;} tpsm_note_s;
   logic clk, rst, scl_low, sda_low, scl_oe, sda_oe, scl, sda, ack, hold;
   logic [6:0] addr;
   logic [7:0] tmo, refr;
   logic wake, tog, cfgv, bdone, sdone, touch, prox, buzz;
   logic [2:0] state;
   logic restore, sstart, sall, sprox, odrv, gen, gdef, lp;
   logic [7:0] flags;
   tpsm_note_s notes[$];
   tpsm_pkg::tpsm_state_e st_q[$];
   event chk_ev;
   int fails, total_checks;
   string nm[9] = '{"STATE_O", "OUT_DRIVE_O", "GEN_OUT_EN_O",
      "GEN_OUT_DEFAULT_O", "SCAN_PROX_ONLY_O", "SCAN_ALL_O",
      "RESTORE_O", "LOW_POWER_O", "link or scan timing"};
   // Wired-and of both parties on the link
   assign scl = ~(scl_low | scl_oe | hold);
   assign sda = ~(sda_low | sda_oe);
   assign flags = {lp, restore, sall, sprox, gdef, gen, odrv, 1'b0};
   tpsm_top #(.MS_CYCLES(10)) dut (.REF_CLK_I(clk), .RST_I(rst),
      .SCL_I(scl), .SCL_O(), .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(),
      .SDA_OE_O(sda_oe), .SLAVE_ADDR_I(addr), .TIMEOUT_SEC_I(tmo),
      .REFRESH_MS_I(refr), .WAKE_APPROACH_EN_I(wake), .TOGGLE_EN_I(tog),
      .CFG_VALID_I(cfgv), .BOOT_DONE_I(bdone), .SCAN_DONE_I(sdone),
      .TOUCH_I(touch), .PROX_I(prox), .BUZZER_ON_I(buzz), .STATE_O(state),
      .RESTORE_O(restore), .DIAG_RUN_O(), .SCAN_START_O(sstart),
      .SCAN_ALL_O(sall), .SCAN_PROX_ONLY_O(sprox), .OUT_DRIVE_O(odrv),
      .GEN_OUT_EN_O(gen), .GEN_OUT_DEFAULT_O(gdef), .LOW_POWER_O(lp));
   tpsm_host host (.sda_i(sda), .scl_low_o(scl_low), .sda_low_o(sda_low));
   // 100 MHz reference clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Sensing engine answers each scan start three cycles later
   always @(negedge clk) begin
      if (sstart === 1'b1) begin
         repeat (3) @(posedge clk);
         #2 sdone = 1'b1;
         @(posedge clk);
         #2 sdone = 1'b0;
      end
   end
   // Comparison of a state code
   task automatic cmp_state(input logic [2:0] e, input logic [2:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] STATE_O expected %0h seen %0h", e, g);
      end
   endtask
   // Comparison of a single flag
   task automatic cmp_bit(input int k, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %b seen %b", nm[k], e, g);
      end
   endtask
   // Monitor takes the oldest note and compares it
   always @(chk_ev) begin
      tpsm_note_s n;
      n = notes.pop_front();
      if (n.kind == 0) cmp_state(st_q.pop_front(), state);
      else if (n.kind == 8) cmp_bit(8, n.exp, n.aux);
      else cmp_bit(n.kind, n.exp, flags[n.kind]);
   end
   // Record an expectation and hand it to the monitor
   task automatic note(input int k, input logic e, input logic a = 1'b0);
      notes.push_back('{k, e, a});
      #1 -> chk_ev;
   endtask
   // Wait a bounded time for a state, then check it
   task automatic go(input tpsm_pkg::tpsm_state_e s, input int lim);
      for (int i = 0; i < lim && state !== s; i++) begin
         @(posedge clk);
         #2;
      end
      st_q.push_back(s);
      note(0, 1'b0);
   endtask
   // Spacing between two scan starts must fall in lo..hi cycles
   task automatic gap(input int lo, input int hi);
      int c;
      c = 1;
      for (int i = 0; i < hi && sstart !== 1'b1; i++) @(negedge clk);
      @(negedge clk);
      while (sstart !== 1'b1 && c < hi + 50) begin
         @(negedge clk);
         c++;
      end
      note(8, 1'b1, c >= lo && c <= hi);
   endtask
   // Low-power flag shortly after a finished scan
   task automatic lp_after_scan(input logic e);
      for (int i = 0; i < 300 && sstart !== 1'b1; i++) @(negedge clk);
      repeat (8) @(negedge clk);
      note(7, e);
   endtask
   task automatic give_verdict;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Watchdog cuts a hang short
   initial begin
      #1_000_000;
      fails++;
      give_verdict;
   end
   // Main sequence
   initial begin
      rst = 1'b1;
      {wake, cfgv, bdone, sdone, touch, prox, buzz} = 7'h00;
      tog = 1'b1;
      hold = 1'b0;
      tmo = 8'h00;
      void'($urandom(54));
      addr = 7'h08 + 7'($urandom % 112);
      refr = 8'h02 + 8'($urandom % 4);
      repeat (12) @(posedge clk);
      #2 rst = 1'b0;
      note(6, 1'b1);
      go(tpsm_pkg::ST_BOOT, 1);
      bdone = 1'b1;
      go(tpsm_pkg::ST_CONFIG, 10);
      note(5, 1'b0);
      $display("test boot and corrupt configuration done");
      rst = 1'b1;
      repeat (2) @(posedge clk);
      go(tpsm_pkg::ST_BOOT, 0);
      #2 rst = 1'b0;
      {cfgv, touch} = 2'b11;
      go(tpsm_pkg::ST_ACTIVE, 20);
      note(1, 1'b1);
      note(5, 1'b1);
      gap(200, 210);
      $display("test active scanning done");
      {touch, buzz} = 2'b01;
      repeat (50) @(posedge clk);
      go(tpsm_pkg::ST_ACTIVE, 0);
      buzz = 1'b0;
      go(tpsm_pkg::ST_TOUCH, 20);
      note(2, 1'b1);
      note(1, 1'b0);
      gap(refr * 10, refr * 10 + 10);
      wake = 1'b1;
      repeat (100) @(posedge clk);
      go(tpsm_pkg::ST_TOUCH, 0);
      tog = 1'b0;
      go(tpsm_pkg::ST_PROX, 20);
      note(4, 1'b1);
      note(2, 1'b0);
      {wake, prox} = 2'b01;
      go(tpsm_pkg::ST_TOUCH, 20);
      {prox, touch} = 2'b01;
      go(tpsm_pkg::ST_ACTIVE, 20);
      $display("test search states done");
      tmo = 8'h01;
      touch = 1'b0;
      repeat (5000) @(posedge clk);
      #2 touch = 1'b1;
      @(posedge clk);
      #2 touch = 1'b0;
      lp_after_scan(1'b1);
      repeat (8700) @(posedge clk);
      go(tpsm_pkg::ST_ACTIVE, 0);
      go(tpsm_pkg::ST_TOUCH, 2000);
      $display("test state timeout done");
      {tmo, touch} = 9'h001;
      go(tpsm_pkg::ST_ACTIVE, 20);
      host.xfer(addr, tpsm_pkg::CMD_REG_PTR, tpsm_pkg::CMD_SLEEP_ENTER, ack);
      note(8, 1'b1, ack);
      go(tpsm_pkg::ST_SLEEP, 20);
      note(3, 1'b1);
      note(5, 1'b0);
      @(posedge clk);
      #2;
      note(7, 1'b1);
      host.xfer(addr, tpsm_pkg::CMD_REG_PTR, tpsm_pkg::CMD_SLEEP_EXIT, ack);
      note(8, 1'b0, ack);
      go(tpsm_pkg::ST_ACTIVE, 50);
      host.xfer_retry(addr, tpsm_pkg::CMD_REG_PTR,
                      tpsm_pkg::CMD_SLEEP_EXIT, ack);
      note(8, 1'b1, ack);
      hold = 1'b1;
      lp_after_scan(1'b0);
      hold = 1'b0;
      $display("test sleep and wake done");
      addr = 7'h7F;
      bdone = 1'b0;
      host.xfer_retry(7'h37, tpsm_pkg::CMD_REG_PTR,
                      tpsm_pkg::CMD_SOFT_RESTART, ack);
      note(8, 1'b1, ack);
      go(tpsm_pkg::ST_BOOT, 50);
      bdone = 1'b1;
      go(tpsm_pkg::ST_ACTIVE, 20);
      host.xfer_retry(7'h37, 8'h10, 8'h55, ack);
      go(tpsm_pkg::ST_CONFIG, 50);
      repeat (300) @(posedge clk);
      go(tpsm_pkg::ST_CONFIG, 0);
      $display("test restart and configuration done");
      give_verdict;
   end
endmodule
`default_nettype wire

// ===== src/tpsm_pkg.sv
// Constants and state codes for the touch power state manager
`default_nettype none
package tpsm_pkg;
   // =======================================================
   // Operational states
   typedef enum logic [2:0] {
      ST_BOOT = 3'h0,
      ST_ACTIVE = 3'h1,
      ST_TOUCH = 3'h2,
      ST_PROX = 3'h3,
      ST_SLEEP = 3'h4,
      ST_CONFIG = 3'h5
   } tpsm_state_e;
   // =======================================================
   // Timing
   localparam int REF_CLK_HZ = 100_000_000;
   localparam int MS_PER_SEC = 1000;
   localparam int ACTIVE_PERIOD_MS = 20;
   localparam int XFER_GAP_MS = 340;
   localparam int MS_CYCLES = REF_CLK_HZ / MS_PER_SEC;
   // =======================================================
   // Link address and command codes
   localparam logic [6:0] ADDR_DEFAULT = 7'h37;
   localparam logic [6:0] ADDR_MIN = 7'h08;
   localparam logic [6:0] ADDR_MAX = 7'h77;
   localparam logic [7:0] CMD_REG_PTR = 8'h86;
   localparam logic [7:0] CMD_SOFT_RESTART = 8'hFF;
   localparam logic [7:0] CMD_SLEEP_ENTER = 8'h07;
   localparam logic [7:0] CMD_SLEEP_EXIT = 8'h08;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [1:0] IDX_ADDR = 2'h0;
   localparam logic [1:0] IDX_PTR = 2'h1;
   localparam logic [1:0] IDX_DATA = 2'h2;
endpackage
`default_nettype wire

// ===== src/tpsm_top.sv
// Touch controller operational state manager with link slave
// Notes on behaviour
// - Boot restores configuration and runs diagnostics first
// - Active scans all, period max(scan, 20 ms)
// - Touch-search scans all slowly, general outputs live
// - Proximity-search scans proximity only, no outputs
// - Deep sleep: no scanning, outputs to default
// - Configuration state idles until reset
// - Host commands sleep entry and exit
// - Config write or corrupt config enters configuration
// - Proximity-search needs wake enabled, toggle disabled
// - Presence in proximity-search goes to touch-search
// - Touch goes active, stays while touched
// - Leave active for touch-search only untouched and buzzer idle
// - No proximity plus timeout steps to proximity-search
// - Timeout in seconds gates both step-downs
// - Refresh interval spaces slow scans; active 20 ms
// - Low power after each period's scan
// - Bus activity or low clock blocks low power
// - All resets lead to boot
// - Soft restart command restarts through boot
// - Link runs up to 400 kbps
// - Responds at configurable 7-bit address
// - Never stretches clock or stalls bus
// - Address range 0x08..0x77, default 0x37
// - Wake on address, NACK until active
// - Long inter-byte gap may allow low power
`default_nettype none
module tpsm_top #(
   parameter int MS_CYCLES = tpsm_pkg::MS_CYCLES
) (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   // Link pins
   input wire logic SCL_I,
   output logic SCL_O,
   output logic SCL_OE_O,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_O,
   // Configuration
   input wire logic [6:0] SLAVE_ADDR_I,
   input wire logic [7:0] TIMEOUT_SEC_I,
   input wire logic [7:0] REFRESH_MS_I,
   input wire logic WAKE_APPROACH_EN_I,
   input wire logic TOGGLE_EN_I,
   input wire logic CFG_VALID_I,
   // Sensing engine
   input wire logic BOOT_DONE_I,
   input wire logic SCAN_DONE_I,
   input wire logic TOUCH_I,
   input wire logic PROX_I,
   input wire logic BUZZER_ON_I,
   // Control outputs
   output logic [2:0] STATE_O,
   output logic RESTORE_O,
   output logic DIAG_RUN_O,
   output logic SCAN_START_O,
   output logic SCAN_ALL_O,
   output logic SCAN_PROX_ONLY_O,
   output logic OUT_DRIVE_O,
   output logic GEN_OUT_EN_O,
   output logic GEN_OUT_DEFAULT_O,
   output logic LOW_POWER_O
);
   // =======================================================
   // Declarations
   tpsm_pkg::tpsm_state_e state_r, state_nxt;
   logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   logic at_m, at_s, at_d, wt_m, wt_s, wt_d;
   logic start_ev, stop_ev, scl_edge;
   logic bus_busy_r, lnk_clr_r, bus_quiet, lnk_rst;
   logic [31:0] cyc_cnt_r;
   logic ms_tick, sec_tick;
   logic [9:0] ms_in_sec_r;
   logic [8:0] gap_ms_r, scan_ms_r, period_ms;
   logic [7:0] sec_cnt_r;
   logic tmo_hit, tmo_rst, run_st, scan_busy_r, scan_go;
   logic addr_ev, wr_ev, cmd_hit, soft_cmd, slp_in, slp_out, cfg_mod;
   logic ready_r, rdy_m, rdy_s;
   logic [6:0] adr_m, adr_s;
   logic [3:0] bit_cnt_r;
   logic [1:0] byte_idx_r;
   logic [7:0] sh_r, byte_w, ptr_r, wptr_r, wdat_r, tx_m, tx_s;
   logic match_r, rw_r, addr_tgl_r, wr_tgl_r, sda_oe_r;
   logic [2:0] tx_idx;

   // =======================================================
   // Pin synchronisers and bus condition detection
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         {scl_m, scl_s, scl_d} <= 3'h7;
         {sda_m, sda_s, sda_d} <= 3'h7;
      end else begin
         {scl_m, scl_s, scl_d} <= {SCL_I, scl_m, scl_s};
         {sda_m, sda_s, sda_d} <= {SDA_I, sda_m, sda_s};
      end
   end

   assign start_ev = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_ev = scl_s & scl_d & ~sda_d & sda_s;
   assign scl_edge = scl_s ^ scl_d;

   // Millisecond and second ticks; seconds restart with activity
   assign ms_tick = (cyc_cnt_r == 32'(MS_CYCLES - 1));
   assign sec_tick = ms_tick &&
      (ms_in_sec_r == 10'(tpsm_pkg::MS_PER_SEC - 1));

   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cyc_cnt_r <= 32'h0;
         ms_in_sec_r <= 10'h0;
      end else begin
         cyc_cnt_r <= ms_tick ? 32'h0 : cyc_cnt_r + 32'h1;
         if (sec_tick || tmo_rst) begin
            ms_in_sec_r <= 10'h0;
         end else if (ms_tick) begin
            ms_in_sec_r <= ms_in_sec_r + 10'h1;
         end
      end
   end

   // Transfer tracking; a stalled transfer stops blocking low power
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         bus_busy_r <= 1'b0;
         gap_ms_r <= 9'h0;
         lnk_clr_r <= 1'b1;
      end else begin
         if (start_ev) begin
            bus_busy_r <= 1'b1;
         end else if (stop_ev) begin
            bus_busy_r <= 1'b0;
         end
         if (start_ev || scl_edge) begin
            gap_ms_r <= 9'h0;
         end else if (ms_tick &&
                      gap_ms_r < 9'(tpsm_pkg::XFER_GAP_MS)) begin
            gap_ms_r <= gap_ms_r + 9'h1;
         end
         // Holds link logic clear from bus condition to clock low
         if (start_ev || stop_ev) begin
            lnk_clr_r <= 1'b1;
         end else if (!scl_s) begin
            lnk_clr_r <= 1'b0;
         end
      end
   end

   assign bus_quiet = (!bus_busy_r && scl_s) ||
      (gap_ms_r >= 9'(tpsm_pkg::XFER_GAP_MS));

   // =======================================================
   // Events crossing from the link clock
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         {at_m, at_s, at_d} <= 3'h0;
         {wt_m, wt_s, wt_d} <= 3'h0;
      end else begin
         {at_m, at_s, at_d} <= {addr_tgl_r, at_m, at_s};
         {wt_m, wt_s, wt_d} <= {wr_tgl_r, wt_m, wt_s};
      end
   end

   assign addr_ev = at_s ^ at_d;
   assign wr_ev = wt_s ^ wt_d;
   assign cmd_hit = wr_ev && (wptr_r == tpsm_pkg::CMD_REG_PTR);
   assign soft_cmd = cmd_hit &&
      (wdat_r == tpsm_pkg::CMD_SOFT_RESTART);
   assign slp_in = cmd_hit && (wdat_r == tpsm_pkg::CMD_SLEEP_ENTER);
   assign slp_out = cmd_hit && (wdat_r == tpsm_pkg::CMD_SLEEP_EXIT);
   assign cfg_mod = wr_ev && (wptr_r != tpsm_pkg::CMD_REG_PTR);

   // =======================================================
   // Operational state machine
   assign tmo_hit = (sec_cnt_r >= TIMEOUT_SEC_I);

   always_comb begin
      state_nxt = state_r;
      if (soft_cmd) begin
         state_nxt = tpsm_pkg::ST_BOOT;
      end else begin
         unique case (state_r)
            tpsm_pkg::ST_BOOT: begin
               if (BOOT_DONE_I) begin
                  state_nxt = CFG_VALID_I ? tpsm_pkg::ST_ACTIVE :
                     tpsm_pkg::ST_CONFIG;
               end
            end
            tpsm_pkg::ST_ACTIVE: begin
               if (cfg_mod) begin
                  state_nxt = tpsm_pkg::ST_CONFIG;
               end else if (slp_in) begin
                  state_nxt = tpsm_pkg::ST_SLEEP;
               end else if (!TOUCH_I && !BUZZER_ON_I && tmo_hit) begin
                  state_nxt = tpsm_pkg::ST_TOUCH;
               end
            end
            tpsm_pkg::ST_TOUCH: begin
               if (cfg_mod) begin
                  state_nxt = tpsm_pkg::ST_CONFIG;
               end else if (slp_in) begin
                  state_nxt = tpsm_pkg::ST_SLEEP;
               end else if (TOUCH_I || addr_ev) begin
                  state_nxt = tpsm_pkg::ST_ACTIVE;
               end else if (!PROX_I && tmo_hit && WAKE_APPROACH_EN_I &&
                            !TOGGLE_EN_I) begin
                  state_nxt = tpsm_pkg::ST_PROX;
               end
            end
            tpsm_pkg::ST_PROX: begin
               if (cfg_mod) begin
                  state_nxt = tpsm_pkg::ST_CONFIG;
               end else if (slp_in) begin
                  state_nxt = tpsm_pkg::ST_SLEEP;
               end else if (addr_ev) begin
                  state_nxt = tpsm_pkg::ST_ACTIVE;
               end else if (PROX_I) begin
                  state_nxt = tpsm_pkg::ST_TOUCH;
               end
            end
            tpsm_pkg::ST_SLEEP: begin
               if (slp_out || addr_ev) begin
                  state_nxt = tpsm_pkg::ST_ACTIVE;
               end
            end
            tpsm_pkg::ST_CONFIG: begin
               state_nxt = tpsm_pkg::ST_CONFIG;
            end
            default: begin
               state_nxt = tpsm_pkg::ST_BOOT;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         state_r <= tpsm_pkg::ST_BOOT;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Inactivity seconds, restarted by touch, proximity or state change
   assign tmo_rst = TOUCH_I || PROX_I || (state_nxt != state_r);

   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         sec_cnt_r <= 8'h0;
      end else if (tmo_rst) begin
         sec_cnt_r <= 8'h0;
      end else if (sec_tick && sec_cnt_r != 8'hFF) begin
         sec_cnt_r <= sec_cnt_r + 8'h1;
      end
   end

   // =======================================================
   // Scan scheduling: next scan waits for period and last scan
   assign run_st = (state_r == tpsm_pkg::ST_ACTIVE) ||
      (state_r == tpsm_pkg::ST_TOUCH) || (state_r == tpsm_pkg::ST_PROX);
   assign period_ms = (state_r == tpsm_pkg::ST_ACTIVE) ?
      9'(tpsm_pkg::ACTIVE_PERIOD_MS) : {1'b0, REFRESH_MS_I};
   assign scan_go = run_st && (state_nxt == state_r) &&
      !scan_busy_r && (scan_ms_r > period_ms); // full period

   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         scan_busy_r <= 1'b0;
         scan_ms_r <= 9'h1FF;
         SCAN_START_O <= 1'b0;
      end else begin
         SCAN_START_O <= scan_go;
         if (!run_st) begin
            scan_busy_r <= 1'b0;
            scan_ms_r <= 9'h1FF;
         end else if (scan_go) begin
            scan_busy_r <= 1'b1;
            scan_ms_r <= 9'h0;
         end else begin
            if (SCAN_DONE_I) begin
               scan_busy_r <= 1'b0;
            end
            if (ms_tick && scan_ms_r != 9'h1FF) begin
               scan_ms_r <= scan_ms_r + 9'h1;
            end
         end
      end
   end

   // =======================================================
   // State decoded outputs, aligned with the state register
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         STATE_O <= 3'h0;
         RESTORE_O <= 1'b1;
         DIAG_RUN_O <= 1'b1;
         SCAN_ALL_O <= 1'b0;
         SCAN_PROX_ONLY_O <= 1'b0;
         OUT_DRIVE_O <= 1'b0;
         GEN_OUT_EN_O <= 1'b0;
         GEN_OUT_DEFAULT_O <= 1'b0;
         ready_r <= 1'b0;
      end else begin
         STATE_O <= state_nxt;
         RESTORE_O <= (state_nxt == tpsm_pkg::ST_BOOT);
         DIAG_RUN_O <= (state_nxt == tpsm_pkg::ST_BOOT);
         SCAN_ALL_O <= (state_nxt == tpsm_pkg::ST_ACTIVE) ||
            (state_nxt == tpsm_pkg::ST_TOUCH);
         SCAN_PROX_ONLY_O <= (state_nxt == tpsm_pkg::ST_PROX);
         OUT_DRIVE_O <= (state_nxt == tpsm_pkg::ST_ACTIVE);
         GEN_OUT_EN_O <= (state_nxt == tpsm_pkg::ST_ACTIVE) ||
            (state_nxt == tpsm_pkg::ST_TOUCH);
         GEN_OUT_DEFAULT_O <= (state_nxt == tpsm_pkg::ST_SLEEP);
         ready_r <= (state_nxt == tpsm_pkg::ST_ACTIVE) ||
            (state_nxt == tpsm_pkg::ST_CONFIG);
      end
   end

   // Low power between scans unless the bus is in use
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         LOW_POWER_O <= 1'b0;
      end else begin
         LOW_POWER_O <= (state_r == tpsm_pkg::ST_SLEEP) ||
            (run_st && !scan_busy_r && !scan_go &&
             bus_quiet);
      end
   end

   // Clock and data output values held released
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         SCL_O <= 1'b0;
         SCL_OE_O <= 1'b0;
         SDA_O <= 1'b0;
      end else begin
         SCL_O <= 1'b0;
         SCL_OE_O <= 1'b0;
         SDA_O <= 1'b0;
      end
   end

   assign SDA_OE_O = sda_oe_r;

   // =======================================================
   // Link clock domain: byte receive, ack and status read
   assign lnk_rst = RST_I | lnk_clr_r;
   assign byte_w = {sh_r[6:0], SDA_I};
   assign tx_idx = 3'h7 - bit_cnt_r[2:0];

   always_ff @(posedge SCL_I or posedge RST_I) begin
      if (RST_I) begin
         {adr_m, adr_s} <= {tpsm_pkg::ADDR_DEFAULT, tpsm_pkg::ADDR_DEFAULT};
         {rdy_m, rdy_s} <= 2'h0;
         {tx_m, tx_s} <= 16'h0;
      end else begin
         adr_m <= (SLAVE_ADDR_I >= tpsm_pkg::ADDR_MIN &&
            SLAVE_ADDR_I <= tpsm_pkg::ADDR_MAX) ? SLAVE_ADDR_I :
            tpsm_pkg::ADDR_DEFAULT;
         adr_s <= adr_m;
         {rdy_m, rdy_s} <= {ready_r, rdy_m};
         {tx_m, tx_s} <= {{5'h0, STATE_O}, tx_m};
      end
   end

   // Toggles and their words survive transfer ends
   always_ff @(posedge SCL_I or posedge RST_I) begin
      if (RST_I) begin
         addr_tgl_r <= 1'b0;
         wr_tgl_r <= 1'b0;
         wptr_r <= 8'h0;
         wdat_r <= 8'h0;
      end else if (bit_cnt_r == tpsm_pkg::LAST_BIT) begin
         if (byte_idx_r == tpsm_pkg::IDX_ADDR &&
             byte_w[7:1] == adr_s) begin
            addr_tgl_r <= ~addr_tgl_r;
         end
         if (byte_idx_r == tpsm_pkg::IDX_DATA && match_r && !rw_r) begin
            wr_tgl_r <= ~wr_tgl_r;
            wptr_r <= ptr_r;
            wdat_r <= byte_w;
         end
      end
   end

   // Per-transfer state, cleared at every bus condition
   always_ff @(posedge SCL_I or posedge lnk_rst) begin
      if (lnk_rst) begin
         bit_cnt_r <= 4'h0;
         byte_idx_r <= 2'h0;
         sh_r <= 8'h0;
         match_r <= 1'b0;
         rw_r <= 1'b0;
         ptr_r <= 8'h0;
      end else if (bit_cnt_r == tpsm_pkg::ACK_BIT) begin
         bit_cnt_r <= 4'h0;
         if (byte_idx_r != tpsm_pkg::IDX_DATA) begin
            byte_idx_r <= byte_idx_r + 2'h1;
         end
      end else begin
         bit_cnt_r <= bit_cnt_r + 4'h1;
         sh_r <= byte_w;
         if (bit_cnt_r == tpsm_pkg::LAST_BIT) begin
            if (byte_idx_r == tpsm_pkg::IDX_ADDR) begin
               match_r <= (byte_w[7:1] == adr_s) && rdy_s;
               rw_r <= byte_w[0];
            end else if (match_r && !rw_r) begin
               ptr_r <= (byte_idx_r == tpsm_pkg::IDX_PTR) ? byte_w :
                  ptr_r + 8'h1;
            end
         end
      end
   end

   // Data line driven on the falling clock only; never holds SCL
   always_ff @(negedge SCL_I or posedge lnk_rst) begin
      if (lnk_rst) begin
         sda_oe_r <= 1'b0;
      end else if (bit_cnt_r == tpsm_pkg::ACK_BIT) begin
         sda_oe_r <= match_r && (!rw_r ||
            byte_idx_r == tpsm_pkg::IDX_ADDR);
      end else begin
         sda_oe_r <= match_r && rw_r &&
            byte_idx_r != tpsm_pkg::IDX_ADDR && !tx_s[tx_idx];
      end
   end

   // =======================================================
   // Checks
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);

   chk_boot_restore: assert property (
      STATE_O == 3'(tpsm_pkg::ST_BOOT) |-> RESTORE_O && DIAG_RUN_O &&
      !SCAN_START_O) else $error("boot without restore");
   chk_boot_wait: assert property (
      STATE_O == 3'(tpsm_pkg::ST_BOOT) && !BOOT_DONE_I && !soft_cmd
      |=> STATE_O == 3'(tpsm_pkg::ST_BOOT)) else $error("early boot exit");
   chk_scan_spacing: assert property (
      scan_busy_r && !SCAN_DONE_I |=> !SCAN_START_O)
      else $error("scan overlaps");
   chk_prox_quiet: assert property (
      STATE_O == 3'(tpsm_pkg::ST_PROX) |-> !GEN_OUT_EN_O &&
      !OUT_DRIVE_O && SCAN_PROX_ONLY_O) else $error("prox drives out");
   chk_sleep_idle: assert property (
      STATE_O == 3'(tpsm_pkg::ST_SLEEP) |-> GEN_OUT_DEFAULT_O &&
      !SCAN_START_O ##1 LOW_POWER_O) else $error("sleep not idle");
   chk_config_hold: assert property (
      STATE_O == 3'(tpsm_pkg::ST_CONFIG) && !soft_cmd
      |=> STATE_O == 3'(tpsm_pkg::ST_CONFIG)) else $error("config left");
   chk_prox_entry: assert property (
      $rose(STATE_O == 3'(tpsm_pkg::ST_PROX)) |->
      $past(STATE_O) == 3'(tpsm_pkg::ST_TOUCH) &&
      $past(WAKE_APPROACH_EN_I) && !$past(TOGGLE_EN_I))
      else $error("bad prox entry");
   chk_active_stay: assert property (
      STATE_O == 3'(tpsm_pkg::ST_ACTIVE) && TOUCH_I && !wr_ev
      |=> STATE_O == 3'(tpsm_pkg::ST_ACTIVE)) else $error("left active");
   chk_lp_bus: assert property (
      !bus_quiet && state_r != tpsm_pkg::ST_SLEEP |=> !LOW_POWER_O)
      else $error("low power during bus use");
   chk_soft_boot: assert property (
      soft_cmd |=> STATE_O == 3'(tpsm_pkg::ST_BOOT) && RESTORE_O)
      else $error("soft restart missed");
   chk_no_stretch: assert property (
      !SCL_OE_O) else $error("clock stretched");
endmodule
`default_nettype wire
